// ---- sixsd_top.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "sixsd_consts.svh"
module sixsd_top
   import sixsd_pkg::*;
#(
   parameter int NCH = `SX_NCH,
   parameter int W = `SX_CIC_W
) (
   // Clock, reset, enable
   input wire logic clk_i,
   input wire logic arst_n_i,
   input wire logic ce_i,
   // Modulator bit streams, one per channel (asynchronous pins)
   input wire logic [NCH-1:0] mod_bit_i,
   // Control bytes and gain codes
   input wire sixsd_ctrl_t ctrl_i,
   input wire logic [NCH-1:0][2:0] gain_code_i,
   // Incoming control words from the serial side
   input wire logic ctrl_word_valid_i,
   output logic ctrl_word_taken_o,
   // Gain stage drive
   output logic [NCH-1:0][2:0] gain_code_o,
   output logic [NCH-1:0][5:0] gain_db_o,
   // Sample frames toward the serial port
   output logic frame_valid_o,
   output sixsd_frame_t frame_o,
   input wire logic frame_ready_i,
   // Status
   output logic overrun_o,
   output logic sample_strobe_o
);
   typedef struct packed {
      logic [NCH-1:0] sync1;
      logic [NCH-1:0] sync2;
      logic [2:0] div_cnt;
      logic dm_tick;
      logic [2:0] ph;
      logic [4:0] dec;
      logic mod_stb;
      logic dec_stb;
      logic [NCH-1:0][W-1:0] i1;
      logic [NCH-1:0][W-1:0] i2;
      logic [NCH-1:0][W-1:0] i3;
      logic [NCH-1:0][W-1:0] d1;
      logic [NCH-1:0][W-1:0] d2;
      logic [NCH-1:0][W-1:0] d3;
      logic [NCH-1:0][14:0] res;
      logic push;
      logic overrun;
      logic taken;
      logic [NCH-1:0][2:0] gcode;
      logic [NCH-1:0][5:0] gdb;
   } sixsd_st_t;
   sixsd_st_t st_reg, st_next;

   logic buf_ready;
   sixsd_frame_t frame_fmt;

   initial begin
      if (NCH != `SX_NCH) $error("channel count must match the frame carrier");
      if (W != `SX_CIC_W) $error("filter width must hold 32 cubed");
   end

   function automatic logic [5:0] gain_db(input logic [2:0] code);
      case (code)
         3'h0: gain_db = 6'h00;
         3'h1: gain_db = 6'h06;
         3'h2: gain_db = 6'h0C;
         3'h3: gain_db = 6'h12;
         3'h4: gain_db = 6'h14;
         3'h5: gain_db = 6'h1A;
         3'h6: gain_db = 6'h20;
         default: gain_db = 6'h26;
      endcase
   endfunction

   // Filter output sits in 0..32768; removing the midpoint gives the signed word
   function automatic logic [14:0] to_signed15(input logic [W-1:0] c3);
      logic [W-1:0] r;
      r = c3 - `SX_CIC_OFF;
      if (!r[W-1] && (r > {2'h0, `SX_POS_FS}))
         to_signed15 = `SX_POS_FS;
      else
         to_signed15 = r[14:0];
   endfunction

   function automatic logic [15:0] fmt(input logic [14:0] v, input logic mixed);
      if (mixed)
         fmt = {`SX_DATA_FLAG, v};
      else if (v == `SX_POS_FS)
         fmt = `SX_CLIP_WORD;
      else
         fmt = {v, 1'h0};
   endfunction

   always_comb begin
      logic [2:0] ratio;
      logic data_mode;
      logic mixed;
      logic [W-1:0] c1;
      logic [W-1:0] c2;
      c1 = '0;
      c2 = '0;
      // Bit numbering: index 7 is the most significant control bit
      data_mode = ctrl_i.serial_mode[`SX_DATA_MODE_BIT];
      mixed = data_mode && ctrl_i.serial_mode[`SX_MIXED_BIT];
      ratio = ctrl_i.clk_div[`SX_DIV_HI:`SX_DIV_LO];
      st_next = st_reg;
      if (ratio > `SX_DIV_MAX) ratio = 3'h0;
      st_next.sync1 = mod_bit_i;
      st_next.sync2 = st_reg.sync1;
      // Divided device clock as a one-cycle tick
      st_next.dm_tick = (st_reg.div_cnt == ratio);
      st_next.div_cnt = (st_reg.div_cnt >= ratio) ? 3'h0 : st_reg.div_cnt + 3'h1;
      st_next.mod_stb = 1'b0;
      st_next.dec_stb = 1'b0;
      if (st_reg.dm_tick) begin
         st_next.ph = st_reg.ph + 3'h1;
         if (st_reg.ph == `SX_PH_LAST) begin
            st_next.mod_stb = 1'b1;
            st_next.dec = st_reg.dec + 5'h1;
            st_next.dec_stb = (st_reg.dec == `SX_DEC_LAST);
         end
      end
      for (int ch = 0; ch < NCH; ch++) begin
         // Each channel has its own gain, input and filter state
         st_next.gcode[ch] = gain_code_i[ch];
         st_next.gdb[ch] = gain_db(gain_code_i[ch]);
         if (st_reg.mod_stb) begin
            st_next.i1[ch] = st_reg.i1[ch] + {{(W-1){1'b0}}, st_reg.sync2[ch]};
            st_next.i2[ch] = st_reg.i2[ch] + st_reg.i1[ch];
            st_next.i3[ch] = st_reg.i3[ch] + st_reg.i2[ch];
         end
         if (st_reg.dec_stb) begin
            // Wrapping arithmetic is exact since the full gain fits in W bits
            c1 = st_reg.i3[ch] - st_reg.d1[ch];
            c2 = c1 - st_reg.d2[ch];
            st_next.d1[ch] = st_reg.i3[ch];
            st_next.d2[ch] = c1;
            st_next.d3[ch] = c2;
            st_next.res[ch] = to_signed15(c2 - st_reg.d3[ch]);
         end
      end
      st_next.push = st_reg.dec_stb;
      // A full buffer drops the whole frame rather than tearing channels apart
      st_next.overrun = st_reg.push && !buf_ready;
      st_next.taken = ctrl_word_valid_i && (!data_mode || mixed);
      for (int ch = 0; ch < NCH; ch++) begin
         frame_fmt.word[ch] = fmt(st_reg.res[ch], mixed);
      end
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         st_reg <= '0;
      end else if (ce_i) begin
         st_reg <= st_next;
      end
   end

   sixsd_buf #(
      .W($bits(sixsd_frame_t)),
      .DEPTH(`SX_BUF_DEPTH)
   ) u_buf (
      .clk_i(clk_i),
      .arst_n_i(arst_n_i),
      .ce_i(ce_i),
      .in_valid_i(st_reg.push),
      .in_data_i(frame_fmt),
      .in_ready_o(buf_ready),
      .out_valid_o(frame_valid_o),
      .out_data_o(frame_o),
      .out_ready_i(frame_ready_i)
   );

   assign ctrl_word_taken_o = st_reg.taken;
   assign gain_code_o = st_reg.gcode;
   assign gain_db_o = st_reg.gdb;
   assign overrun_o = st_reg.overrun;
   assign sample_strobe_o = st_reg.push;

   default clocking @(posedge clk_i); endclocking
   // A frozen enable holds every strobe at its last value, so checks pause with it
   default disable iff (!arst_n_i || !ce_i);

   sequence s_mod_quiet;
      !st_reg.mod_stb [*7];
   endsequence
   sequence s_dec_quiet;
      !st_reg.dec_stb [*8];
   endsequence

   AST_GAIN_MAP: assert property (
      ce_i && gain_code_i[0] == 3'h4 |=> gain_db_o[0] == 6'h14)
      else $error("gain code 4 not mapped to 20 dB");
   AST_MOD_SPACING: assert property (
      st_reg.mod_stb |=> s_mod_quiet)
      else $error("modulator bits taken closer than eight ticks");
   AST_DEC_ON_MOD: assert property (
      st_reg.dec_stb |-> st_reg.mod_stb ##1 s_dec_quiet)
      else $error("output strobe not aligned to input strobe");
   AST_TWOS: assert property (
      ce_i && st_reg.dec_stb && st_reg.i3[1] == st_reg.d1[1] && st_reg.d2[1] == '0
      && st_reg.d3[1] == '0 |=> st_reg.res[1][14])
      else $error("zero filter output not negative");
   AST_SHIFT: assert property (
      st_reg.push && !ctrl_i.serial_mode[`SX_MIXED_BIT]
      && st_reg.res[1] != `SX_POS_FS |-> frame_fmt.word[1][0] == 1'b0)
      else $error("16-bit word lsb not cleared");
   AST_CLIP: assert property (
      !ctrl_i.serial_mode[`SX_MIXED_BIT] && st_reg.res[0] == `SX_POS_FS
      |-> frame_fmt.word[0] == `SX_CLIP_WORD)
      else $error("full scale not clipped to 7FFF");
   AST_MIXED_FLAG: assert property (
      ctrl_i.serial_mode[`SX_DATA_MODE_BIT] && ctrl_i.serial_mode[`SX_MIXED_BIT]
      |-> frame_fmt.word[2] == {`SX_DATA_FLAG, st_reg.res[2]})
      else $error("mixed word lacks data flag");
   AST_DIV5: assert property (
      st_reg.dm_tick && ctrl_i.clk_div[`SX_DIV_HI:`SX_DIV_LO] == 3'h4
      && $stable(ctrl_i.clk_div) |=> !st_reg.dm_tick [*4])
      else $error("divide by five ticks too fast");
   AST_DATA_IGNORE: assert property (
      ce_i && ctrl_word_valid_i && ctrl_i.serial_mode[`SX_DATA_MODE_BIT]
      && !ctrl_i.serial_mode[`SX_MIXED_BIT] |=> !ctrl_word_taken_o)
      else $error("control word taken in data mode");
   AST_SAME_STROBE: assert property (
      ce_i && st_reg.dec_stb |=> sample_strobe_o)
      else $error("results not published after shared strobe");
endmodule
`default_nettype wire

// ---- sixsd_consts.svh ----
// How it works
// - Each channel keeps a 3-bit gain code mapped to 0..38 dB
// - Each channel takes one modulator bit every eight device clock ticks
// - Decimator turns device clock /8 input into one 15-bit word per /256
// - Filter is three cascaded 32-tap moving sums, a sinc-cubed response
// - Results are two's complement, negative input gives negative code
// - 16-bit format shifts the 15-bit result left, LSB forced to zero
// - At or above positive full scale the 16-bit word is 0x7FFF
// - Mixed format sends 15 bits with the top bit as data flag
// - Device clock comes from the pin clock through a programmable divider
// - Result registers update at the sample rate from the device clock
// - Six independent channels, each with own gain, input and filter
// - Control bits numbered 0 to 7, bit 7 most significant
// - With the data mode bit set and the mixed bit clear, incoming control words are ignored
// - Clock divider offers divide by 1 (default) through 5 by code field
`ifndef SIXSD_CONSTS_SVH
`define SIXSD_CONSTS_SVH
`define SX_NCH 6
`define SX_CIC_W 17
`define SX_DATA_MODE_BIT 0
`define SX_MIXED_BIT 1
`define SX_DIV_HI 7
`define SX_DIV_LO 5
`define SX_DIV_MAX 3'h4
`define SX_PH_LAST 3'h7
`define SX_DEC_LAST 5'h1F
`define SX_CIC_OFF 17'h04000
`define SX_POS_FS 15'h3FFF
`define SX_CLIP_WORD 16'h7FFF
`define SX_DATA_FLAG 1'h0
`define SX_BUF_DEPTH 2
`endif

// ---- sixsd_pkg.sv ----
`default_nettype none
`include "sixsd_consts.svh"
package sixsd_pkg;
   typedef struct packed {
      logic [`SX_NCH-1:0][15:0] word;
   } sixsd_frame_t;
   typedef struct packed {
      logic [7:0] serial_mode;
      logic [7:0] clk_div;
   } sixsd_ctrl_t;
endpackage
`default_nettype wire

// ---- sixsd_buf.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "sixsd_consts.svh"
module sixsd_buf #(
   parameter int W = 96,
   parameter int DEPTH = `SX_BUF_DEPTH
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic arst_n_i,
   input wire logic ce_i,
   // Fill side
   input wire logic in_valid_i,
   input wire logic [W-1:0] in_data_i,
   output logic in_ready_o,
   // Drain side
   output logic out_valid_o,
   output logic [W-1:0] out_data_o,
   input wire logic out_ready_i
);
   typedef struct packed {
      logic [1:0][W-1:0] ent;
      logic [1:0] cnt;
      logic vld;
      logic rdy;
   } sixsd_buf_st_t;
   sixsd_buf_st_t st_reg, st_next;

   initial begin
      if (DEPTH != 2) $error("sixsd_buf supports depth 2 only");
   end

   always_comb begin
      logic pop;
      logic push;
      logic [1:0] c;
      pop = st_reg.vld && out_ready_i;
      push = in_valid_i && st_reg.rdy;
      st_next = st_reg;
      c = st_reg.cnt;
      if (pop) begin
         st_next.ent[0] = st_reg.ent[1];
         c = c - 2'h1;
      end
      if (push) begin
         st_next.ent[c[0]] = in_data_i;
         c = c + 2'h1;
      end
      st_next.cnt = c;
      // Flags kept as flops so the top sees registered handshakes
      st_next.vld = (c != 2'h0);
      st_next.rdy = (c != 2'h2);
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         st_reg <= '0;
         st_reg.rdy <= 1'b1;
      end else if (ce_i) begin
         st_reg <= st_next;
      end
   end

   assign in_ready_o = st_reg.rdy;
   assign out_valid_o = st_reg.vld;
   assign out_data_o = st_reg.ent[0];
endmodule
`default_nettype wire

// ---- sixsd_sink.sv ----
`timescale 1ns/100ps
`default_nettype none
module sixsd_sink
   import sixsd_pkg::*;
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic arst_n_i,
   // Frame stream
   input wire logic frame_valid_i,
   input wire sixsd_frame_t frame_i,
   output logic frame_ready_o,
   // Bench control and capture
   input wire logic stall_i,
   output sixsd_frame_t got_o,
   output logic got_new_o
);
   // Ready moves only after an edge, so a stall never splits a transfer
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         frame_ready_o <= 1'b0;
         got_o <= '0;
         got_new_o <= 1'b0;
      end else begin
         frame_ready_o <= !stall_i;
         got_new_o <= frame_valid_i && frame_ready_o;
         if (frame_valid_i && frame_ready_o) begin
            got_o <= frame_i;
         end
      end
   end
endmodule
`default_nettype wire

// ---- sixsd_top_tb.sv ----
`timescale 1ns/100ps
`default_nettype none
module sixsd_top_tb;
   import sixsd_pkg::*;
   logic clk_i = 1'b0;
   logic arst_n_i = 1'b0;
   logic ce_i = 1'b1;
   logic [5:0] mod_bit_i = '0;
   sixsd_ctrl_t ctrl_i = '0;
   logic [5:0][2:0] gain_code_i = '0;
   logic ctrl_word_valid_i = 1'b0;
   logic taken, fvalid, fready, overrun, strobe, got_new;
   logic stall = 1'b1;
   logic alt = 1'b0;
   logic [5:0][2:0] gcode;
   logic [5:0][5:0] gdb;
   sixsd_frame_t frame, got;
   int bad_count = 0;
   int n_tests = 0;
   int ovr = 0;
   int gap = 0;
   int last_gap = 0;
   int tick = 0;
   int divn = 1;
   logic [5:0] db_tab [8] = '{6'h00, 6'h06, 6'h0C, 6'h12, 6'h14, 6'h1A, 6'h20, 6'h26};

   sixsd_top i_dut (.clk_i(clk_i), .arst_n_i(arst_n_i), .ce_i(ce_i), .mod_bit_i(mod_bit_i),
      .ctrl_i(ctrl_i), .gain_code_i(gain_code_i), .ctrl_word_valid_i(ctrl_word_valid_i),
      .ctrl_word_taken_o(taken), .gain_code_o(gcode), .gain_db_o(gdb),
      .frame_valid_o(fvalid), .frame_o(frame), .frame_ready_i(fready),
      .overrun_o(overrun), .sample_strobe_o(strobe));
   sixsd_sink i_sink (.clk_i(clk_i), .arst_n_i(arst_n_i), .frame_valid_i(fvalid),
      .frame_i(frame), .frame_ready_o(fready), .stall_i(stall), .got_o(got),
      .got_new_o(got_new));

   always #20 clk_i = ~clk_i;

   // Ch0 full scale, ch1 zero, rest alternate once per modulator sample
   always @(negedge clk_i) begin
      tick++;
      if (tick % (8 * divn) == 0) alt = ~alt;
      mod_bit_i <= {{4{alt}}, 1'b0, 1'b1};
   end

   always @(negedge clk_i) begin
      gap++;
      if (strobe === 1'b1) begin
         last_gap = gap;
         gap = 0;
      end
      if (overrun === 1'b1) ovr++;
   end

   task automatic chk_w(input logic [15:0] g, input logic [15:0] e);
      n_tests++;
      if (g !== e) begin
         bad_count++;
         $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask

   task automatic close_out;
      $display("comparisons=%0d mismatches=%0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask

   // Wait for the sink to take a frame, bounded by the slowest divider
   task automatic next_frame;
      int k;
      k = 0;
      @(negedge clk_i);
      while (got_new !== 1'b1 && k < 3000) begin
         @(negedge clk_i);
         k++;
      end
      chk_w({15'h0000, got_new}, 16'h0001);
   endtask

   task automatic chk_frame(input logic [15:0] e0, input logic [15:0] e1, input logic [15:0] ea);
      chk_w(got.word[0], e0);
      chk_w(got.word[1], e1);
      for (int c = 2; c < 6; c++) chk_w(got.word[c], ea);
   endtask

   task automatic send_word(input logic [7:0] mode, input logic e);
      @(negedge clk_i);
      ctrl_i.serial_mode = mode;
      ctrl_word_valid_i = 1'b1;
      @(negedge clk_i);
      ctrl_word_valid_i = 1'b0;
      chk_w({15'h0000, taken}, {15'h0000, e});
   endtask

   initial begin
      repeat (3) @(negedge clk_i);
      arst_n_i = 1'b1;
      for (int g = 0; g < 8; g++) begin
         gain_code_i[0] = 3'(g);
         gain_code_i[5] = 3'(7 - g);
         @(negedge clk_i);
         chk_w({10'h000, gdb[0]}, {10'h000, db_tab[g]});
         chk_w({13'h0000, gcode[0]}, 16'(g));
         chk_w({10'h000, gdb[5]}, {10'h000, db_tab[7 - g]});
      end
      // Enable low freezes every register, gain drive included
      ce_i = 1'b0;
      gain_code_i[0] = 3'h1;
      repeat (3) @(negedge clk_i);
      chk_w({10'h000, gdb[0]}, {10'h000, db_tab[7]});
      ce_i = 1'b1;
      @(negedge clk_i);
      chk_w({10'h000, gdb[0]}, {10'h000, db_tab[1]});
      send_word(8'h00, 1'b1);
      send_word(8'h01, 1'b0);
      send_word(8'h03, 1'b1);
      ctrl_i.serial_mode = 8'h00;
      stall = 1'b0;
      repeat (5) next_frame;
      chk_frame(16'h7FFF, 16'h8000, 16'h0000);
      chk_w(16'(last_gap), 16'h0100);
      ctrl_i.serial_mode = 8'h03;
      repeat (2) next_frame;
      chk_frame(16'h3FFF, 16'h4000, 16'h0000);
      for (int c = 0; c < 6; c++) begin
         ctrl_i.clk_div = {3'(c), 5'h00};
         divn = (c < 5) ? c + 1 : 1;
         repeat (2) next_frame;
         chk_w(16'(last_gap), 16'(256 * divn));
      end
      ctrl_i.clk_div = 8'h00;
      // Sink stalls: two frames fit, the third must be dropped
      stall = 1'b1;
      ovr = 0;
      repeat (900) @(negedge clk_i);
      chk_w(16'(ovr), 16'h0001);
      chk_w({15'h0000, fvalid}, 16'h0001);
      stall = 1'b0;
      repeat (2) next_frame;
      chk_frame(16'h3FFF, 16'h4000, 16'h0000);
      close_out;
   end

   initial begin
      #1000000;
      bad_count++;
      close_out;
   end
endmodule
`default_nettype wire
